// file: dv/flash_host_model.sv
// Host programmer model that drives the parallel strobes of the flash sequencer
`timescale 1ns/1ps
module flash_host_model (
  // Clock
  input  wire logic                            i_core_clk,
  // Pins toward the device
  output logic      [flash_seq_pkg::ROW_W-1:0] o_addr,
  output logic                                 o_row_col_strobe,
  output logic                                 o_write_strobe_n,
  output logic                                 o_output_gate_n,
  output logic      [7:0]                      o_dq,
  // Pins from the device
  input  wire logic [7:0]                      i_dq_out,
  input  wire logic                            i_dq_oe
);
  logic                                        oe_seen;  // Output enable seen at the last read sample
  // All strobes idle high from time zero
  initial begin
    o_addr = '0;
    o_row_col_strobe = 1'b1;
    o_write_strobe_n = 1'b1;
    o_output_gate_n = 1'b1;
    o_dq = 8'h00;
    oe_seen = 1'b0;
  end

  task automatic put_addr(input logic [21:0] a);
    @(posedge i_core_clk);
    o_addr <= a[10:0];
    o_row_col_strobe <= 1'b0;
    @(posedge i_core_clk);
    o_addr <= a[21:11];
    o_row_col_strobe <= 1'b1;
  endtask

  // one write cycle; data lines flip after release so stale data never looks valid
  task automatic write(input logic [21:0] a, input logic [7:0] d, input logic gate_n);
    put_addr(a);
    @(posedge i_core_clk);
    o_dq <= d;
    o_output_gate_n <= gate_n;
    o_write_strobe_n <= 1'b0;
    @(posedge i_core_clk);
    o_write_strobe_n <= 1'b1;
    @(posedge i_core_clk);
    o_dq <= ~d;
    o_output_gate_n <= 1'b1;
  endtask

  // Strobe pulse far shorter than one clock; the device must not take it
  task automatic glitch_write(input logic [21:0] a, input logic [7:0] d);
    put_addr(a);
    @(posedge i_core_clk);
    o_dq <= d;
    #5 o_write_strobe_n = 1'b0;
    #3 o_write_strobe_n = 1'b1;
  endtask

  // reads only valid array addresses; sampled after the output register settles
  task automatic read(input logic [21:0] a, output logic [7:0] d);
    put_addr(a);
    @(posedge i_core_clk);
    o_output_gate_n <= 1'b0;
    repeat (4) @(posedge i_core_clk);
    #1 d = i_dq_out;
    oe_seen = i_dq_oe;
    @(posedge i_core_clk);
    o_output_gate_n <= 1'b1;
  endtask
endmodule

// file: dv/testbench.sv
// Self-checking bench for the parallel-mode flash command sequencer
`timescale 1ns/1ps
module testbench;
  localparam int MEM_AW = 13;             // Two sectors keep erase short
  localparam int BLOCK_BYTES = 2048;      // Shrunk block size
  localparam logic [7:0] MAKER_ID = 8'h3c; // Arbitrary value
  localparam logic [7:0] PART_ID = 8'hc3;  // Arbitrary value
  // Clock, reset and pins
  logic                              i_core_clk = 1'b0;
  logic                              i_resetn = 1'b0;
  logic [flash_seq_pkg::ROW_W-1:0]   pin_addr;
  logic                              pin_rc;
  logic                              pin_we_n;
  logic                              pin_oe_n;
  logic [7:0]                        pin_dq_in;
  logic [7:0]                        o_dq_out;
  logic                              o_dq_oe;
  logic                              o_busy;
  // Counters and read results
  int                                err_total = 0;
  int                                compares = 0;
  logic [7:0]                        rd;
  logic [7:0]                        rd2;
  logic [21:0]                       unl_a;
  logic [21:0]                       unl_b;
  assign unl_a = {6'h00, flash_seq_pkg::ADDR_UNLOCK_A};
  assign unl_b = {6'h00, flash_seq_pkg::ADDR_UNLOCK_B};

  // Free-running 50 MHz clock
  always #10 i_core_clk = ~i_core_clk;

  flash_host_model host_u (.i_core_clk(i_core_clk), .o_addr(pin_addr), .o_row_col_strobe(pin_rc),
    .o_write_strobe_n(pin_we_n), .o_output_gate_n(pin_oe_n), .o_dq(pin_dq_in), .i_dq_out(o_dq_out),
    .i_dq_oe(o_dq_oe));
  flash_seq #(.MEM_AW(MEM_AW), .BLOCK_BYTES(BLOCK_BYTES), .MAKER_ID(MAKER_ID), .PART_ID(PART_ID)) dut_u (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_addr(pin_addr), .i_row_col_strobe(pin_rc),
    .i_write_strobe_n(pin_we_n), .i_output_gate_n(pin_oe_n), .i_dq_in(pin_dq_in),
    .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe), .o_busy(o_busy));

  // Byte compare
  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Single bit compare
  task automatic check1(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask
  // Verdict and end of run
  task automatic tally_and_finish;
    $display("TB: %0d compares, %0d mismatches", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Bounded wait for the busy flag, then compare it
  task automatic wait_busy(input logic val, input int limit);
    int n;
    n = 0;
    while (o_busy !== val && n < limit) begin
      @(posedge i_core_clk);
      #1 n++;
    end
    check1(o_busy, val, "busy level");
  endtask
  // Three-cycle guard lead-in ending with a command
  task automatic unlock3(input logic [7:0] cmd, input logic gate_n);
    host_u.write(unl_a, flash_seq_pkg::CMD_UNLOCK_A, gate_n);
    host_u.write(unl_b, flash_seq_pkg::CMD_UNLOCK_B, gate_n);
    host_u.write(unl_a, cmd, gate_n);
  endtask
  // Six-cycle erase sequence
  task automatic erase6(input logic [21:0] a, input logic [7:0] cmd);
    unlock3(flash_seq_pkg::CMD_ERASE_SETUP, 1'b1);
    host_u.write(unl_a, flash_seq_pkg::CMD_UNLOCK_A, 1'b1);
    host_u.write(unl_b, flash_seq_pkg::CMD_UNLOCK_B, 1'b1);
    host_u.write(a, cmd, 1'b1);
  endtask
  // Program one byte and wait for busy to rise; the caller waits for the end and the settle interval
  task automatic program_byte(input logic [21:0] a, input logic [7:0] d);
    unlock3(flash_seq_pkg::CMD_PROGRAM, 1'b1);
    host_u.write(a, d, 1'b1);
    wait_busy(1'b1, 4);
  endtask

  // Watchdog well beyond the roughly 20k cycles the tests need
  initial begin
    #(20 * 60000);
    err_total++;
    $display("ERROR at %0t: watchdog expired", $time);
    tally_and_finish();
  end

  // Main sequence
  initial begin
    repeat (2) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    unlock3(flash_seq_pkg::CMD_ID_ENTRY, 1'b1);
    host_u.read(22'h000000, rd);
    check8(rd, MAKER_ID, "maker code");
    check1(host_u.oe_seen, 1'b1, "output enable on read");
    host_u.read(22'h000001, rd);
    check8(rd, PART_ID, "part code");
    host_u.write(unl_a, flash_seq_pkg::CMD_ID_EXIT, 1'b1);
    check1(o_dq_oe, 1'b0, "output enable off with gate high");
    $display("TB: identification test done");
    erase6(unl_a, flash_seq_pkg::CMD_CHIP_ERASE);
    wait_busy(1'b1, 4);
    host_u.read(22'h000010, rd);
    check1(rd[7], 1'b0, "erase poll bit");
    host_u.read(22'h000010, rd2);
    check1(rd2[6], ~rd[6], "erase toggle bit");
    program_byte(22'h000010, 8'h00);
    wait_busy(1'b0, 8400);
    host_u.read(22'h000010, rd);
    check8(rd, flash_seq_pkg::ERASED_BYTE, "chip erased, write ignored");
    host_u.read(22'h001fff, rd);
    check8(rd, flash_seq_pkg::ERASED_BYTE, "chip erased top");
    $display("TB: chip erase test done");
    program_byte(22'h000010, 8'h3d);
    host_u.read(22'h000010, rd);
    check1(rd[7], ~(8'h3d >> 7), "program poll bit");
    host_u.read(22'h000010, rd2);
    check1(rd2[6], ~rd[6], "program toggle bit");
    wait_busy(1'b0, 1100);
    host_u.read(22'h000010, rd);
    check1(rd[7], 1'b0, "poll bit true after program");
    repeat (flash_seq_pkg::SETTLE_CYCLES) @(posedge i_core_clk);
    host_u.read(22'h000010, rd);
    check8(rd, 8'h3d, "programmed byte");
    host_u.read(22'h000010, rd2);
    check8(rd2, 8'h3d, "toggle stopped");
    program_byte(22'h001010, 8'hc4);
    wait_busy(1'b0, 1100);
    repeat (flash_seq_pkg::SETTLE_CYCLES) @(posedge i_core_clk);
    $display("TB: program test done");
    erase6(22'h001000, flash_seq_pkg::CMD_SECTOR_ERASE);
    wait_busy(1'b1, 4);
    wait_busy(1'b0, flash_seq_pkg::SECTOR_BYTES + 100);
    host_u.read(22'h001010, rd);
    check8(rd, flash_seq_pkg::ERASED_BYTE, "sector erased");
    host_u.read(22'h000010, rd);
    check8(rd, 8'h3d, "other sector kept");
    erase6(22'h000000, flash_seq_pkg::CMD_BLOCK_ERASE);
    wait_busy(1'b1, 4);
    wait_busy(1'b0, BLOCK_BYTES + 100);
    host_u.read(22'h000010, rd);
    check8(rd, flash_seq_pkg::ERASED_BYTE, "block erased");
    $display("TB: sector and block erase test done");
    host_u.write(unl_a, flash_seq_pkg::CMD_UNLOCK_A, 1'b1);
    host_u.write(unl_b, 8'h77, 1'b1);
    host_u.write(unl_a, flash_seq_pkg::CMD_PROGRAM, 1'b1);
    host_u.write(22'h000020, 8'h00, 1'b1);
    repeat (4) @(posedge i_core_clk);
    check1(o_busy, 1'b0, "aborted sequence");
    unlock3(flash_seq_pkg::CMD_PROGRAM, 1'b0);
    host_u.write(22'h000020, 8'h00, 1'b0);
    repeat (4) @(posedge i_core_clk);
    check1(o_busy, 1'b0, "write inhibited");
    unlock3(flash_seq_pkg::CMD_PROGRAM, 1'b1);
    host_u.glitch_write(22'h000020, 8'h00);
    repeat (4) @(posedge i_core_clk);
    check1(o_busy, 1'b0, "glitch ignored");
    host_u.read(22'h000020, rd);
    check8(rd, flash_seq_pkg::ERASED_BYTE, "byte untouched");
    $display("TB: protection test done");
    tally_and_finish();
  end
endmodule

// file: verilog/flash_seq.sv
// Parallel-mode flash command sequencer with status polling and identification
`timescale 1ns/1ps
module flash_seq #(
  parameter int MEM_AW      = 20,          // Array address bits
  parameter int BLOCK_BYTES = 65536,       // Block erase size (16384 on smallest part)
  parameter logic [7:0] MAKER_ID = 8'h11,  // Arbitrary value
  parameter logic [7:0] PART_ID  = 8'h22   // Arbitrary value
) (
  // Clock and reset
  input  wire logic                                i_core_clk,
  input  wire logic                                i_resetn,
  // Multiplexed address and strobes
  input  wire logic [flash_seq_pkg::ROW_W-1:0]     i_addr,
  input  wire logic                                i_row_col_strobe,
  input  wire logic                                i_write_strobe_n,
  input  wire logic                                i_output_gate_n,
  // Data pins
  input  wire logic [7:0]                          i_dq_in,
  output logic      [7:0]                          o_dq_out,
  output logic                                     o_dq_oe,
  // Operation in progress
  output logic                                     o_busy
);
  // Strobe history and latched fields
  logic                        we_q;          // Write strobe one cycle ago
  logic                        rc_q;          // Row/column strobe one cycle ago
  logic                        oe_q;          // Output gate one cycle ago
  logic [3:0]                  we_low_cnt;    // Length of current strobe low
  logic [7:0]                  wr_data;       // Data held while strobe is low
  flash_seq_pkg::flash_addr_t  lat_addr;      // Latched row and column
  flash_seq_pkg::seq_state_t   state;         // Sequencer state
  flash_seq_pkg::seq_state_t   next_state;
  logic                        id_mode;       // Identification mode active
  logic                        toggle;        // Alternating status bit
  logic [7:0]                  prog_byte;     // Byte under program
  logic [15:0]                 cnt;           // Program and settle timer
  logic [MEM_AW-1:0]           erase_ptr;     // Byte being erased
  logic [MEM_AW-1:0]           erase_last;    // Last byte of erase region
  logic [7:0]                  mem_rd;        // Array read data
  logic [7:0]                  mem [0:(2**MEM_AW)-1];  // Flash array
  logic [7:0]                  next_dq;

  // Decode wires
  localparam logic [MEM_AW-1:0] SEC_MASK = MEM_AW'(flash_seq_pkg::SECTOR_BYTES - 1);
  localparam logic [MEM_AW-1:0] BLK_MASK = MEM_AW'(BLOCK_BYTES - 1);
  localparam logic [MEM_AW-1:0] ALL_ONES = '1;
  wire logic [flash_seq_pkg::FULL_AW-1:0] full_addr = lat_addr;
  wire logic [MEM_AW-1:0] mem_addr = full_addr[MEM_AW-1:0];
  wire logic is_a = (full_addr[15:0] == flash_seq_pkg::ADDR_UNLOCK_A);
  wire logic is_b = (full_addr[15:0] == flash_seq_pkg::ADDR_UNLOCK_B);
  wire logic we_long = (we_low_cnt >= 4'(flash_seq_pkg::WE_MIN_CYCLES));
  wire logic we_ev = i_write_strobe_n & ~we_q & we_long & i_output_gate_n;
  wire logic rd_now = ~i_output_gate_n & i_write_strobe_n;
  wire logic oe_fall = oe_q & ~i_output_gate_n;
  wire logic busy = (state == flash_seq_pkg::ST_PROGRAM) | (state == flash_seq_pkg::ST_ERASE);
  wire logic erase_done = (erase_ptr == erase_last);
  wire logic prog_done = (cnt == 16'(flash_seq_pkg::PROG_CYCLES - 1));
  wire logic settle_done = (cnt == 16'(flash_seq_pkg::SETTLE_CYCLES - 1));
  wire logic sec_go = we_ev & (state == flash_seq_pkg::ST_ERASE_CMD) & (wr_data == flash_seq_pkg::CMD_SECTOR_ERASE);
  wire logic blk_go = we_ev & (state == flash_seq_pkg::ST_ERASE_CMD) & (wr_data == flash_seq_pkg::CMD_BLOCK_ERASE);
  wire logic chip_go = we_ev & (state == flash_seq_pkg::ST_ERASE_CMD) & is_a
                       & (wr_data == flash_seq_pkg::CMD_CHIP_ERASE);
  wire logic prog_go = we_ev & (state == flash_seq_pkg::ST_PROG_DATA);
  wire logic id_on = we_ev & (state == flash_seq_pkg::ST_UNLOCK2) & is_a & (wr_data == flash_seq_pkg::CMD_ID_ENTRY);
  wire logic id_off = we_ev & ((state == flash_seq_pkg::ST_READ) | (state == flash_seq_pkg::ST_UNLOCK2))
                      & (wr_data == flash_seq_pkg::CMD_ID_EXIT);
  // Array write port: erase walk or program byte
  wire logic mem_we = (state == flash_seq_pkg::ST_ERASE) | prog_go;
  wire logic [MEM_AW-1:0] mem_wa = (state == flash_seq_pkg::ST_ERASE) ? erase_ptr : mem_addr;
  wire logic [7:0] mem_wd = (state == flash_seq_pkg::ST_ERASE) ? flash_seq_pkg::ERASED_BYTE : wr_data;

  // Strobe history; data follows the pins while the write strobe is low
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      we_q       <= 1'b1;
      rc_q       <= 1'b1;
      oe_q       <= 1'b1;
      we_low_cnt <= 4'h0;
      wr_data    <= 8'h00;
    end else begin
      we_q <= i_write_strobe_n;
      rc_q <= i_row_col_strobe;
      oe_q <= i_output_gate_n;
      // Saturating width count so long pulses do not wrap below the limit
      if (i_write_strobe_n) begin
        we_low_cnt <= 4'h0;
      end else if (we_low_cnt != 4'hf) begin
        we_low_cnt <= we_low_cnt + 4'h1;
      end
      if (!i_write_strobe_n) begin
        wr_data <= i_dq_in;
      end
    end
  end

  // Row on falling and column on rising edge of the row/column strobe
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      lat_addr <= '0;
    end else begin
      if (rc_q && !i_row_col_strobe) begin
        lat_addr.row <= i_addr;
      end
      if (!rc_q && i_row_col_strobe) begin
        lat_addr.col <= i_addr;
      end
    end
  end

  // Next state; only accepted strobes move the command sequence
  always_comb begin
    next_state = state;
    case (state)
      flash_seq_pkg::ST_READ: begin
        if (we_ev && is_a && wr_data == flash_seq_pkg::CMD_UNLOCK_A) begin
          next_state = flash_seq_pkg::ST_UNLOCK1;
        end
      end
      flash_seq_pkg::ST_UNLOCK1: begin
        if (we_ev) begin
          next_state = (is_b && wr_data == flash_seq_pkg::CMD_UNLOCK_B) ? flash_seq_pkg::ST_UNLOCK2
                                                                          : flash_seq_pkg::ST_READ;
        end
      end
      flash_seq_pkg::ST_UNLOCK2: begin
        if (we_ev) begin
          if (is_a && wr_data == flash_seq_pkg::CMD_ERASE_SETUP) begin
            next_state = flash_seq_pkg::ST_ERASE_U0;
          end else if (is_a && wr_data == flash_seq_pkg::CMD_PROGRAM) begin
            next_state = flash_seq_pkg::ST_PROG_DATA;
          end else begin
            next_state = flash_seq_pkg::ST_READ;
          end
        end
      end
      flash_seq_pkg::ST_PROG_DATA: begin
        if (we_ev) begin
          next_state = flash_seq_pkg::ST_PROGRAM;
        end
      end
      flash_seq_pkg::ST_ERASE_U0: begin
        if (we_ev) begin
          next_state = (is_a && wr_data == flash_seq_pkg::CMD_UNLOCK_A) ? flash_seq_pkg::ST_ERASE_U1
                                                                          : flash_seq_pkg::ST_READ;
        end
      end
      flash_seq_pkg::ST_ERASE_U1: begin
        if (we_ev) begin
          next_state = (is_b && wr_data == flash_seq_pkg::CMD_UNLOCK_B) ? flash_seq_pkg::ST_ERASE_CMD
                                                                          : flash_seq_pkg::ST_READ;
        end
      end
      flash_seq_pkg::ST_ERASE_CMD: begin
        if (sec_go || blk_go || chip_go) begin
          next_state = flash_seq_pkg::ST_ERASE;
        end else if (we_ev) begin
          next_state = flash_seq_pkg::ST_READ;
        end
      end
      flash_seq_pkg::ST_PROGRAM: begin
        // strobes are not looked at while busy
        if (prog_done) begin
          next_state = flash_seq_pkg::ST_SETTLE;
        end
      end
      flash_seq_pkg::ST_ERASE: begin
        if (erase_done) begin
          next_state = flash_seq_pkg::ST_READ;
        end
      end
      flash_seq_pkg::ST_SETTLE: begin
        if (settle_done) begin
          next_state = flash_seq_pkg::ST_READ;
        end
      end
      default: begin
        next_state = flash_seq_pkg::ST_READ;
      end
    endcase
  end

  // Sequencer registers, timers and erase region
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state      <= flash_seq_pkg::ST_READ;
      id_mode    <= 1'b0;
      prog_byte  <= 8'h00;
      cnt        <= 16'h0000;
      erase_ptr  <= '0;
      erase_last <= '0;
      o_busy     <= 1'b0;
    end else begin
      state  <= next_state;
      o_busy <= (next_state == flash_seq_pkg::ST_PROGRAM) | (next_state == flash_seq_pkg::ST_ERASE);
      if (id_on) begin
        id_mode <= 1'b1;
      end else if (id_off) begin
        id_mode <= 1'b0;
      end
      // One timer serves program then settle, restarted at each boundary
      if (prog_go || (state == flash_seq_pkg::ST_PROGRAM && prog_done)) begin
        cnt <= 16'h0000;
      end else begin
        cnt <= cnt + 16'h0001;
      end
      if (prog_go) begin
        prog_byte <= wr_data;
      end
      // sector region, block region, whole array
      if (sec_go) begin
        erase_ptr  <= mem_addr & ~SEC_MASK;
        erase_last <= mem_addr | SEC_MASK;
      end else if (blk_go) begin
        erase_ptr  <= mem_addr & ~BLK_MASK;
        erase_last <= mem_addr | BLK_MASK;
      end else if (chip_go) begin
        erase_ptr  <= '0;
        erase_last <= ALL_ONES;
      end else if (state == flash_seq_pkg::ST_ERASE && !erase_done) begin
        erase_ptr <= erase_ptr + MEM_AW'(1);
      end
    end
  end

  // Array storage; one byte per cycle, which also sets the erase time
  always_ff @(posedge i_core_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
    mem_rd <= mem[mem_addr];
  end

  // toggle on each new read while busy
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      toggle <= 1'b0;
    end else if (busy && oe_fall) begin
      toggle <= ~toggle;
    end
  end

  // Read data select; status replaces data while an operation runs
  always_comb begin
    next_dq = mem_rd;
    case (state)
      flash_seq_pkg::ST_PROGRAM: begin
        next_dq = flash_seq_pkg::ZERO_BYTE;
        next_dq[flash_seq_pkg::POLL_BIT]   = ~prog_byte[flash_seq_pkg::POLL_BIT];
        next_dq[flash_seq_pkg::TOGGLE_BIT] = toggle;
      end
      flash_seq_pkg::ST_ERASE: begin
        next_dq = flash_seq_pkg::ZERO_BYTE;
        next_dq[flash_seq_pkg::TOGGLE_BIT] = toggle;
      end
      flash_seq_pkg::ST_SETTLE: begin
        // only bit seven is true yet
        next_dq = flash_seq_pkg::ZERO_BYTE;
        next_dq[flash_seq_pkg::POLL_BIT] = prog_byte[flash_seq_pkg::POLL_BIT];
      end
      default: begin
        if (id_mode) begin
          next_dq = (full_addr == flash_seq_pkg::ID_MAKER_ADDR) ? MAKER_ID :
                    (full_addr == flash_seq_pkg::ID_PART_ADDR)  ? PART_ID  : flash_seq_pkg::ZERO_BYTE;
        end
      end
    endcase
  end

  // Output pins; driven only while the gate is low and no write strobe is low
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_dq_out <= 8'h00;
      o_dq_oe  <= 1'b0;
    end else begin
      o_dq_out <= next_dq;
      o_dq_oe  <= rd_now;
    end
  end

  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  sector_start_a: assert property (sec_go |=> state == flash_seq_pkg::ST_ERASE ##0 (erase_last - erase_ptr) == SEC_MASK)
    else $error("sector erase did not start on 4K region");
  block_start_a: assert property (blk_go && !sec_go |=> (erase_last - erase_ptr) == BLK_MASK)
    else $error("block erase region wrong");
  chip_start_a: assert property (chip_go |=> erase_ptr == '0 ##0 erase_last == ALL_ONES)
    else $error("chip erase region wrong");
  erase_ignore_a: assert property (state == flash_seq_pkg::ST_ERASE && !erase_done |=> state == flash_seq_pkg::ST_ERASE)
    else $error("erase left early");
  erase_poll_a: assert property (state == flash_seq_pkg::ST_ERASE |=> !o_dq_out[flash_seq_pkg::POLL_BIT])
    else $error("poll bit not low during erase");
  prog_poll_a: assert property (state == flash_seq_pkg::ST_PROGRAM |=> o_dq_out[flash_seq_pkg::POLL_BIT] != prog_byte[flash_seq_pkg::POLL_BIT])
    else $error("poll bit not inverted during program");
  toggle_flip_a: assert property (busy && oe_fall |=> toggle != $past(toggle))
    else $error("status bit did not alternate");
  inhibit_hold_a: assert property (!i_output_gate_n && state == flash_seq_pkg::ST_READ |=> state == flash_seq_pkg::ST_READ)
    else $error("write accepted with gate low");
  abort_read_a: assert property (we_ev && state == flash_seq_pkg::ST_UNLOCK1
      && !(is_b && wr_data == flash_seq_pkg::CMD_UNLOCK_B) |=> state == flash_seq_pkg::ST_READ)
    else $error("invalid cycle did not abort");
  settle_len_a: assert property (prog_done && state == flash_seq_pkg::ST_PROGRAM |=> state == flash_seq_pkg::ST_SETTLE [*8])
    else $error("settle interval too short");
  id_maker_a: assert property (id_mode && state == flash_seq_pkg::ST_READ && full_addr == flash_seq_pkg::ID_MAKER_ADDR
                               && $stable(full_addr) |=> o_dq_out == MAKER_ID)
    else $error("maker code not returned");

  prog_seen_c: cover property (prog_go ##[1:1000] state == flash_seq_pkg::ST_SETTLE);
  sector_seen_c: cover property (sec_go);
  chip_seen_c: cover property (chip_go);
  id_seen_c: cover property (id_on);
endmodule

// file: verilog/flash_seq_pkg.sv
// Constants, codes and carrier types for the parallel-mode flash command sequencer
package flash_seq_pkg;
  // Core clock
  localparam int CLK_PERIOD_NS = 20;
  // Least write strobe width, rounded up to whole cycles
  localparam int WE_MIN_NS = 5;
  localparam int WE_MIN_RAW = (WE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WE_MIN_CYCLES = (WE_MIN_RAW < 1) ? 1 : WE_MIN_RAW;
  // Longest program time, rounded down
  localparam int PROG_TIME_NS = 20000;
  localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
  // Settling time of the whole data byte after program, rounded up
  localparam int SETTLE_NS = 1000;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Address pins and assembled address
  localparam int ROW_W = 11;
  localparam int FULL_AW = 2 * ROW_W;
  // Unlock pattern addresses, compared on the low 16 bits
  localparam logic [15:0] ADDR_UNLOCK_A = 16'h5555;
  localparam logic [15:0] ADDR_UNLOCK_B = 16'h2aaa;
  // Command codes
  localparam logic [7:0] CMD_UNLOCK_A = 8'haa;
  localparam logic [7:0] CMD_UNLOCK_B = 8'h55;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_ID_ENTRY = 8'h90;
  localparam logic [7:0] CMD_ID_EXIT = 8'hf0;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_BLOCK_ERASE = 8'h50;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  // Identification byte addresses, and where the system map shows them
  localparam logic [FULL_AW-1:0] ID_MAKER_ADDR = 22'h000000;
  localparam logic [FULL_AW-1:0] ID_PART_ADDR = 22'h000001;
  localparam logic [31:0] SYS_MAKER_ADDR = 32'hffbc0000;
  localparam logic [31:0] SYS_PART_ADDR = 32'hffbc0001;
  // Status bit positions, fill values and sector size
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam int SECTOR_BYTES = 4096;

  // Address as latched from the multiplexed pins
  typedef struct packed {
    logic [ROW_W-1:0] col;
    logic [ROW_W-1:0] row;
  } flash_addr_t;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_READ, ST_UNLOCK1, ST_UNLOCK2, ST_PROG_DATA, ST_ERASE_U0,
    ST_ERASE_U1, ST_ERASE_CMD, ST_PROGRAM, ST_ERASE, ST_SETTLE
  } seq_state_t;
endpackage
